// [rtl/dcd_channel.sv]
// Summary of operation
// - eight-bit loop counter holds iteration count of looping descriptors.
// - loaded destination kind bit makes destination absolute or relative.
// - loaded source kind bit makes source absolute or relative.
// - first descriptor always uses absolute addresses; relative only when linked.
// - destination steps one, two, four units per transfer write; code 3 holds it.
// - source steps one, two, four units per read; code 3 holds it.
// - unit size selects byte, half-word or word; steps scale with it.
// - mask bit set ignores single requests, only burst requests count.
// - pacing 0 moves one block per request; 1 moves whole count.
// - enabled done flag sets on completion, linking or synchronisation.
// - burst length code maps to units per arbitration; 15 means all.
// - endian reverse swaps bytes inside each half-word or word moved.
// - unit count gives units to move minus one and counts down as data moves.
// - linked descriptor with self trigger starts without peripheral request.
// - descriptor kind selects transfer, synchronisation or immediate write.
// - source register written by software, reads back next read address.
// - destination register written by software, reads back next write address.
// - word-aligned link pointer updated after each linked descriptor load.
// - link bit set at completion fetches next descriptor from link pointer.
//
// Register access over APB is this design's own decision.
module dcd_channel (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        req_i,
  input  wire logic        sreq_i,
  output logic             mem_req_o,
  output logic             mem_we_o,
  output logic      [31:0] mem_addr_o,
  output logic      [1:0]  mem_size_o,
  output logic      [31:0] mem_wdata_o,
  input  wire logic        mem_ack_i,
  input  wire logic [31:0] mem_rdata_i,
  output logic             busy_o,
  output logic             done_flag_o,
  output logic      [1:0]  round_robin_share_o
);

  // step an address by one, two or four units (inc code 0, 1, 2) of the given size, up or down
  function automatic logic [31:0] step_addr(input logic [31:0] a, input logic [1:0] inc,
                                            input logic [1:0] size, input logic neg);
    logic [31:0] s;
    s = 32'h0;
    if (inc != dcd_pkg::INC_NONE) s = 32'h1 << ({1'b0, inc} + {1'b0, size});
    return neg ? a - s : a + s;
  endfunction

  // units per arbitration; zero stands for the whole count
  function automatic logic [10:0] burst_units(input logic [3:0] code);
    logic [10:0] u;
    u = 11'h001;
    case (code)
      4'h0: u = 11'h001;
      4'h1: u = 11'h002;
      4'h2: u = 11'h003;
      4'h3: u = 11'h004;
      4'h4: u = 11'h006;
      4'h5: u = 11'h008;
      4'h7: u = 11'h010;
      4'h9: u = 11'h020;
      4'ha: u = 11'h040;
      4'hb: u = 11'h080;
      4'hc: u = 11'h100;
      4'hd: u = 11'h200;
      4'he: u = 11'h400;
      4'hf: u = 11'h000;
      default: u = 11'h001;
    endcase
    return u;
  endfunction

  // byte order reversal within the unit
  function automatic logic [31:0] swap_bytes(input logic [31:0] d, input logic [1:0] size);
    logic [31:0] r;
    r = d;
    if (size == dcd_pkg::SIZE_HALF) r = {d[23:16], d[31:24], d[7:0], d[15:8]};
    else if (size == dcd_pkg::SIZE_WORD) r = {d[7:0], d[15:8], d[23:16], d[31:24]};
    return r;
  endfunction

  dcd_pkg::dcd_state_t state_r;
  dcd_pkg::dcd_state_t state_nxt;
  logic [31:0] cfg_r;
  logic [31:0] ctrl_r;
  logic [31:0] src_r;
  logic [31:0] dst_r;
  logic [31:0] link_r;
  logic [7:0]  loop_r;
  logic [31:0] data_r;
  logic [10:0] blk_left_r;
  logic [1:0]  idx_r;
  logic        pend_r;
  logic        done_r;
  logic        pready_r;
  logic        mem_req_r;

  // field views of the live descriptor
  logic [1:0]  kind;
  logic [1:0]  size;
  logic [10:0] count;
  logic        all_mode;
  logic        wr_en;
  logic        rd_en;
  logic        mem_done;
  logic        idle;
  logic        start_cmd;
  logic        load_cmd;
  logic        blk_start;
  logic        unit_done;
  logic        fetch_last;

  assign kind       = ctrl_r[dcd_pkg::CTRL_KIND +: 2];
  assign size       = ctrl_r[dcd_pkg::CTRL_SIZE +: 2];
  assign count      = ctrl_r[dcd_pkg::CTRL_COUNT +: 11];
  assign all_mode   = ctrl_r[dcd_pkg::CTRL_PACING] ||
                      ctrl_r[dcd_pkg::CTRL_BURST +: 4] == dcd_pkg::BURST_ALL;
  assign wr_en      = psel_i && penable_i && pready_r && pwrite_i;
  assign rd_en      = psel_i && !penable_i && !pready_r;
  assign mem_done   = mem_req_r && mem_ack_i;
  assign idle       = state_r == dcd_pkg::ST_IDLE;
  assign start_cmd  = wr_en && paddr_i == dcd_pkg::OFF_CMD && pwdata_i[dcd_pkg::CMD_START] && idle;
  assign load_cmd   = wr_en && paddr_i == dcd_pkg::OFF_CMD && pwdata_i[dcd_pkg::CMD_LINKLOAD] && idle;
  assign blk_start  = state_r == dcd_pkg::ST_EXEC && kind == dcd_pkg::KIND_XFER && pend_r;
  assign unit_done  = state_r == dcd_pkg::ST_WRITE && mem_done;
  assign fetch_last = state_r == dcd_pkg::ST_FETCH && mem_done && idx_r == dcd_pkg::LAST_WORD;

  // channel sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      dcd_pkg::ST_IDLE: begin
        if (load_cmd) state_nxt = dcd_pkg::ST_FETCH;
        else if (start_cmd) state_nxt = dcd_pkg::ST_EXEC;
      end
      dcd_pkg::ST_EXEC: begin
        case (kind)
          dcd_pkg::KIND_SYNC:  state_nxt = dcd_pkg::ST_FINISH;
          dcd_pkg::KIND_WRITE: state_nxt = dcd_pkg::ST_WRITE;
          default: begin
            if (pend_r) state_nxt = dcd_pkg::ST_READ;
          end
        endcase
      end
      dcd_pkg::ST_READ: begin
        if (mem_done) state_nxt = dcd_pkg::ST_WRITE;
      end
      dcd_pkg::ST_WRITE: begin
        if (mem_done) begin
          if (kind != dcd_pkg::KIND_XFER || count == 11'h000) state_nxt = dcd_pkg::ST_FINISH;
          else if (!all_mode && blk_left_r == 11'h001) state_nxt = dcd_pkg::ST_EXEC;
          else state_nxt = dcd_pkg::ST_READ;
        end
      end
      dcd_pkg::ST_FINISH: begin
        state_nxt = link_r[dcd_pkg::LINK_EN] ? dcd_pkg::ST_FETCH : dcd_pkg::ST_IDLE;
      end
      dcd_pkg::ST_FETCH: begin
        if (fetch_last) state_nxt = dcd_pkg::ST_EXEC;
      end
      default: state_nxt = dcd_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) state_r <= dcd_pkg::ST_IDLE;
    else state_r <= state_nxt;
  end

  // pending request latch; a new request wins over the clear by a starting block
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) pend_r <= 1'b0;
    else if (req_i || (sreq_i && !ctrl_r[dcd_pkg::CTRL_SRQMASK])) pend_r <= 1'b1;
    else if (state_r == dcd_pkg::ST_FETCH && mem_done && idx_r == 2'h0 && mem_rdata_i[dcd_pkg::CTRL_SELF])
      pend_r <= 1'b1;
    else if (blk_start) pend_r <= 1'b0;
  end

  // units left in the current block
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) blk_left_r <= 11'h000;
    else if (blk_start) blk_left_r <= burst_units(ctrl_r[dcd_pkg::CTRL_BURST +: 4]);
    else if (unit_done && blk_left_r != 11'h000) blk_left_r <= blk_left_r - 11'h001;
  end

  // descriptor word index while fetching
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) idx_r <= 2'h0;
    else if (state_r != dcd_pkg::ST_FETCH) idx_r <= 2'h0;
    else if (mem_done) idx_r <= idx_r + 2'h1;
  end

  // channel configuration
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) cfg_r <= dcd_pkg::RST_WORD;
    else if (wr_en && paddr_i == dcd_pkg::OFF_CFG) cfg_r <= pwdata_i & dcd_pkg::CFG_SW_MASK;
  end

  // loop counter; software write overrides the countdown
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) loop_r <= dcd_pkg::RST_LOOP;
    else if (wr_en && paddr_i == dcd_pkg::OFF_LOOP) loop_r <= pwdata_i[7:0];
    else if (state_r == dcd_pkg::ST_FINISH && ctrl_r[dcd_pkg::CTRL_DECLOOP] && loop_r != 8'h00)
      loop_r <= loop_r - 8'h01;
  end

  // control word: software, count-down and descriptor load
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) ctrl_r <= dcd_pkg::RST_WORD;
    else if (wr_en && paddr_i == dcd_pkg::OFF_CTRL && idle)
      ctrl_r <= (ctrl_r & ~dcd_pkg::CTRL_SW_MASK) | (pwdata_i & dcd_pkg::CTRL_SW_MASK);
    else if (state_r == dcd_pkg::ST_FETCH && mem_done && idx_r == 2'h0)
      ctrl_r <= mem_rdata_i & ~(32'h1 << dcd_pkg::CTRL_SELF);
    else if (unit_done && kind == dcd_pkg::KIND_XFER && count != 11'h000)
      ctrl_r[dcd_pkg::CTRL_COUNT +: 11] <= count - 11'h001;
  end

  // source pointer
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) src_r <= dcd_pkg::RST_WORD;
    else if (wr_en && paddr_i == dcd_pkg::OFF_SRC && idle) src_r <= pwdata_i;
    else if (state_r == dcd_pkg::ST_FETCH && mem_done && idx_r == 2'h1)
      src_r <= ctrl_r[dcd_pkg::CTRL_SRCKIND] ? src_r + mem_rdata_i : mem_rdata_i;
    else if (state_r == dcd_pkg::ST_READ && mem_done)
      src_r <= step_addr(src_r, ctrl_r[dcd_pkg::CTRL_SOURCE_STEP_SIZE +: 2], size, cfg_r[dcd_pkg::CFG_SRCDIR]);
  end

  // destination pointer
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) dst_r <= dcd_pkg::RST_WORD;
    else if (wr_en && paddr_i == dcd_pkg::OFF_DST && idle) dst_r <= pwdata_i;
    else if (state_r == dcd_pkg::ST_FETCH && mem_done && idx_r == 2'h2)
      dst_r <= ctrl_r[dcd_pkg::CTRL_DSTKIND] ? dst_r + mem_rdata_i : mem_rdata_i;
    else if (unit_done && kind == dcd_pkg::KIND_XFER)
      dst_r <= step_addr(dst_r, ctrl_r[dcd_pkg::CTRL_DEST_STEP_SIZE +: 2], size, cfg_r[dcd_pkg::CFG_DSTDIR]);
  end

  // link pointer; a relative link is taken from the current descriptor address
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) link_r <= dcd_pkg::RST_WORD;
    else if (wr_en && paddr_i == dcd_pkg::OFF_LINK && idle)
      link_r <= (link_r & ~dcd_pkg::LINK_SW_MASK) | (pwdata_i & dcd_pkg::LINK_SW_MASK);
    else if (fetch_last)
      link_r <= mem_rdata_i[dcd_pkg::LINK_KIND] ?
                {link_r[31:2] + mem_rdata_i[31:2], mem_rdata_i[1:0]} : mem_rdata_i;
  end

  // data held between read and write; immediate kind writes the source field
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) data_r <= dcd_pkg::RST_WORD;
    else if (state_r == dcd_pkg::ST_EXEC) data_r <= src_r;
    else if (state_r == dcd_pkg::ST_READ && mem_done)
      data_r <= ctrl_r[dcd_pkg::CTRL_SWAP] ? swap_bytes(mem_rdata_i, size) : mem_rdata_i;
  end

  // memory access issue: one idle cycle between accesses so the pointers settle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mem_req_r   <= 1'b0;
      mem_we_o    <= 1'b0;
      mem_addr_o  <= dcd_pkg::RST_WORD;
      mem_size_o  <= 2'h0;
      mem_wdata_o <= dcd_pkg::RST_WORD;
    end else if (mem_done) begin
      mem_req_r <= 1'b0;
    end else if (!mem_req_r) begin
      case (state_r)
        dcd_pkg::ST_READ: begin
          mem_req_r  <= 1'b1;
          mem_we_o   <= 1'b0;
          mem_addr_o <= src_r;
          mem_size_o <= size;
        end
        dcd_pkg::ST_WRITE: begin
          mem_req_r   <= 1'b1;
          mem_we_o    <= 1'b1;
          mem_addr_o  <= dst_r;
          mem_size_o  <= kind == dcd_pkg::KIND_XFER ? size : dcd_pkg::SIZE_WORD;
          mem_wdata_o <= data_r;
        end
        dcd_pkg::ST_FETCH: begin
          mem_req_r  <= 1'b1;
          mem_we_o   <= 1'b0;
          mem_addr_o <= {link_r[31:2], 2'h0} + {28'h0, idx_r, 2'h0};
          mem_size_o <= dcd_pkg::SIZE_WORD;
        end
        default: mem_req_r <= 1'b0;
      endcase
    end
  end

  assign mem_req_o = mem_req_r;

  // done flag: completion, linking or sync; set wins over a software clear
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) done_r <= 1'b0;
    else if (state_r == dcd_pkg::ST_FINISH && ctrl_r[dcd_pkg::CTRL_DONEEN]) done_r <= 1'b1;
    else if (wr_en && paddr_i == dcd_pkg::OFF_STAT && pwdata_i[dcd_pkg::STAT_DONE]) done_r <= 1'b0;
  end

  // status outputs from flops
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_o              <= 1'b0;
      done_flag_o         <= 1'b0;
      round_robin_share_o <= 2'h0;
    end else begin
      busy_o              <= state_nxt != dcd_pkg::ST_IDLE;
      done_flag_o         <= done_r;
      round_robin_share_o <= cfg_r[dcd_pkg::CFG_SHARE +: 2];
    end
  end

  // apb slave: no wait states, read data captured in the setup cycle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_r  <= 1'b0;
      prdata_o  <= dcd_pkg::RST_WORD;
      pslverr_o <= 1'b0;
    end else if (rd_en) begin
      pready_r  <= 1'b1;
      pslverr_o <= 1'b0;
      prdata_o  <= dcd_pkg::RST_WORD;
      case (paddr_i)
        dcd_pkg::OFF_CFG:  prdata_o <= cfg_r;
        dcd_pkg::OFF_LOOP: prdata_o <= {24'h0, loop_r};
        dcd_pkg::OFF_CTRL: prdata_o <= ctrl_r;
        dcd_pkg::OFF_SRC:  prdata_o <= src_r;
        dcd_pkg::OFF_DST:  prdata_o <= dst_r;
        dcd_pkg::OFF_LINK: prdata_o <= link_r;
        dcd_pkg::OFF_CMD:  prdata_o <= dcd_pkg::RST_WORD;
        dcd_pkg::OFF_STAT: prdata_o <= {30'h0, done_r, !idle};
        default:           pslverr_o <= 1'b1;
      endcase
    end else begin
      pready_r  <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  assign pready_o = pready_r;

endmodule // dcd_channel

// [rtl/dcd_pkg.sv]
package dcd_pkg;
  // register byte offsets on the apb window
  localparam logic [11:0] OFF_CFG  = 12'h084;
  localparam logic [11:0] OFF_LOOP = 12'h088;
  localparam logic [11:0] OFF_CTRL = 12'h08c;
  localparam logic [11:0] OFF_SRC  = 12'h090;
  localparam logic [11:0] OFF_DST  = 12'h094;
  localparam logic [11:0] OFF_LINK = 12'h098;
  localparam logic [11:0] OFF_CMD  = 12'h09c;
  localparam logic [11:0] OFF_STAT = 12'h0a0;

  // descriptor control word fields
  localparam int CTRL_DSTKIND = 31;
  localparam int CTRL_SRCKIND = 30;
  localparam int CTRL_DEST_STEP_SIZE  = 28;
  localparam int CTRL_SIZE    = 26;
  localparam int CTRL_SOURCE_STEP_SIZE  = 24;
  localparam int CTRL_SRQMASK = 23;
  localparam int CTRL_DECLOOP = 22;
  localparam int CTRL_PACING  = 21;
  localparam int CTRL_DONEEN  = 20;
  localparam int CTRL_BURST   = 16;
  localparam int CTRL_SWAP    = 15;
  localparam int CTRL_COUNT   = 4;
  localparam int CTRL_SELF    = 3;
  localparam int CTRL_KIND    = 0;
  localparam logic [31:0] CTRL_SW_MASK = 32'h3fff_fff0;

  // channel configuration fields
  localparam int CFG_DSTDIR = 21;
  localparam int CFG_SRCDIR = 20;
  localparam int CFG_SHARE  = 16;
  localparam logic [31:0] CFG_SW_MASK = 32'h0033_0000;

  // link word fields
  localparam int LINK_EN   = 1;
  localparam int LINK_KIND = 0;
  localparam logic [31:0] LINK_SW_MASK = 32'hffff_fffe;

  // command and status bits
  localparam int CMD_START    = 0;
  localparam int CMD_LINKLOAD = 1;
  localparam int STAT_BUSY    = 0;
  localparam int STAT_DONE    = 1;

  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [7:0]  RST_LOOP = 8'h00;

  // encodings
  localparam logic [1:0] INC_NONE   = 2'h3;
  localparam logic [1:0] SIZE_HALF  = 2'h1;
  localparam logic [1:0] SIZE_WORD  = 2'h2;
  localparam logic [1:0] KIND_XFER  = 2'h0;
  localparam logic [1:0] KIND_SYNC  = 2'h1;
  localparam logic [1:0] KIND_WRITE = 2'h2;
  localparam logic [3:0] BURST_ALL  = 4'hf;
  localparam logic [1:0] LAST_WORD  = 2'h3;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'b000001,
    ST_EXEC   = 6'b000010,
    ST_READ   = 6'b000100,
    ST_WRITE  = 6'b001000,
    ST_FINISH = 6'b010000,
    ST_FETCH  = 6'b100000
  } dcd_state_t;
endpackage

// [tb/dcd_mem_model.sv]
module dcd_mem_model (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [1:0]  lat_i,
  output logic             ack_o,
  output logic      [31:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [logic [31:0]];
  logic [31:0] wa_q [$];
  logic [31:0] wd_q [$];
  logic [1:0]  wait_r;
  // one ack after lat_i wait cycles; read data flips every cycle it is not valid
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_o   <= 1'b0;
      rdata_o <= 32'h0;
      wait_r  <= 2'h0;
    end else begin
      ack_o   <= 1'b0;
      rdata_o <= ~rdata_o;
      wait_r  <= 2'h0;
      if (req_i && !ack_o && wait_r != lat_i) begin
        wait_r <= wait_r + 2'h1;
      end else if (req_i && !ack_o) begin
        ack_o   <= 1'b1;
        rdata_o <= mem.exists(addr_i) ? mem[addr_i] : {addr_i[15:0], ~addr_i[15:0]};
        if (we_i) begin
          wa_q.push_back(addr_i);
          wd_q.push_back(wdata_i);
        end
      end
    end
  end
endmodule // dcd_mem_model

// [tb/dcd_monitor.sv]
module dcd_monitor (
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic [11:0] paddr_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        mem_req_o,
  input wire logic        mem_we_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic [1:0]  mem_size_o,
  input wire logic        mem_ack_i,
  input wire logic        busy_o,
  input wire logic        done_flag_o,
  input wire logic [1:0]  round_robin_share_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic setup;
  logic rd_cyc;
  // setup cycles; the slave answers in the cycle after
  assign setup  = psel_i && !penable_i;
  assign rd_cyc = setup && !pwrite_i;
  a_ready_next:
    assert property (setup |=> pready_o) else $error("no ready after setup");
  a_err_unmapped:
    assert property (setup && paddr_i == 12'h0fc |=> pslverr_o && pready_o) else $error("unmapped not refused");
  a_share_copy:
    assert property (setup && pwrite_i && paddr_i == dcd_pkg::OFF_CFG ##1 pready_o
      |=> ##1 round_robin_share_o == $past(pwdata_i[17:16], 2)) else $error("share not taken");
  a_loop_width:
    assert property (rd_cyc && paddr_i == dcd_pkg::OFF_LOOP |=> prdata_o[31:8] == 24'h0) else $error("loop wide");
  a_ctrl_hidden:
    assert property (rd_cyc && paddr_i == dcd_pkg::OFF_CTRL |=> prdata_o[3:2] == 2'h0) else $error("ctrl bit read");
  // an access must not move under the memory while it waits for ack
  a_mem_hold:
    assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o))
    else $error("memory request moved");
  a_size_legal:
    assert property (mem_req_o |-> busy_o && mem_size_o != 2'h3) else $error("bad unit size");
  a_done_cause:
    assert property ($rose(done_flag_o) |-> $past(busy_o) || $past(busy_o, 2)) else $error("done without work");
  c_unit_write: cover property (mem_req_o && mem_we_o && mem_ack_i);
  c_done: cover property ($rose(done_flag_o));
  c_refused: cover property (pslverr_o);
endmodule // dcd_monitor

// [tb/tb.sv]
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, resetn, psel, penable, pwrite, pready, pslverr, perr, req, sreq;
  logic        mreq, mwe, mack, busy, done;
  logic [1:0]  msize, share, lat;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, maddr, mwdata, mrdata, r;
  int          miscompares, num_checks, cyc;
  logic [11:0] offs [4] = '{dcd_pkg::OFF_LOOP, dcd_pkg::OFF_SRC, dcd_pkg::OFF_DST, dcd_pkg::OFF_CFG};

  dcd_channel i_dut (.clk_i(clk), .resetn_i(resetn), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .req_i(req), .sreq_i(sreq), .mem_req_o(mreq), .mem_we_o(mwe), .mem_addr_o(maddr), .mem_size_o(msize),
    .mem_wdata_o(mwdata), .mem_ack_i(mack), .mem_rdata_i(mrdata), .busy_o(busy), .done_flag_o(done),
    .round_robin_share_o(share));
  dcd_mem_model i_mem (.clk_i(clk), .resetn_i(resetn), .req_i(mreq), .we_i(mwe), .addr_i(maddr),
    .wdata_i(mwdata), .lat_i(lat), .ack_o(mack), .rdata_o(mrdata));

  // 200 MHz system clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic test_done();
    if (miscompares == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // apb cycle: request held until ready is seen at an edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rd(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(n, e, r);
  endtask
  // one-cycle peripheral request, burst or single
  task automatic kick(input logic burst);
    @(posedge clk);
    req  <= burst;
    sreq <= !burst;
    @(posedge clk);
    req  <= 1'b0;
    sreq <= 1'b0;
  endtask
  task automatic wait_done();
    while (done !== 1'b1) @(posedge clk);
    while (busy !== 1'b0) @(posedge clk);
  endtask
  task automatic chk_wr(input int i, input logic [31:0] a, input logic [31:0] d);
    chk("write address", a, i_mem.wa_q[i]);
    chk("write data", d, i_mem.wd_q[i]);
  endtask
  function automatic logic [31:0] swp(input logic [31:0] a);
    logic [31:0] p;
    p = {a[15:0], ~a[15:0]};
    return {p[7:0], p[15:8], p[23:16], p[31:24]};
  endfunction

  // main sequence
  initial begin
    {psel, penable, pwrite, req, sreq} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    lat = 2'h2;
    resetn = 1'b0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    foreach (offs[i]) rd("reset value", offs[i], 32'h0);
    rd("unmapped read", 12'h0fc, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, perr});
    wr(dcd_pkg::OFF_CFG, 32'hffff_ffff);
    rd("config", dcd_pkg::OFF_CFG, 32'h0033_0000);
    chk("share", 32'h3, {30'h0, share});
    wr(dcd_pkg::OFF_CFG, 32'h0010_0000);
    wr(dcd_pkg::OFF_LOOP, 32'h0000_0105);
    rd("loop", dcd_pkg::OFF_LOOP, 32'h5);
    wr(dcd_pkg::OFF_CTRL, 32'hffff_ffff);
    rd("control", dcd_pkg::OFF_CTRL, 32'h3fff_fff0);
    // three swapped words, source stepping down, slow memory
    wr(dcd_pkg::OFF_SRC, 32'h0000_1000);
    wr(dcd_pkg::OFF_DST, 32'h0000_2000);
    wr(dcd_pkg::OFF_CTRL, 32'h18f0_8020);
    wr(dcd_pkg::OFF_CMD, 32'h1);
    kick(1'b0);
    repeat (8) @(posedge clk);
    rd("masked single", dcd_pkg::OFF_SRC, 32'h0000_1000);
    kick(1'b1);
    wait_done();
    for (int i = 0; i < 3; i++) chk_wr(i, 32'h2000 + 8 * i, swp(32'h1000 - 4 * i));
    rd("source end", dcd_pkg::OFF_SRC, 32'h0000_0ff4);
    rd("destination end", dcd_pkg::OFF_DST, 32'h0000_2018);
    rd("loop", dcd_pkg::OFF_LOOP, 32'h4);
    rd("status", dcd_pkg::OFF_STAT, 32'h2);
    wr(dcd_pkg::OFF_STAT, 32'h2);
    rd("status clear", dcd_pkg::OFF_STAT, 32'h0);
    // bytes from a fixed source, one block per request
    lat <= 2'h0;
    i_mem.wa_q.delete();
    wr(dcd_pkg::OFF_CFG, 32'h0);
    wr(dcd_pkg::OFF_SRC, 32'h0000_3000);
    wr(dcd_pkg::OFF_DST, 32'h0000_4000);
    wr(dcd_pkg::OFF_CTRL, 32'h0310_0010);
    wr(dcd_pkg::OFF_CMD, 32'h1);
    kick(1'b0);
    while (i_mem.wa_q.size() < 1) @(posedge clk);
    repeat (8) @(posedge clk);
    rd("one block", dcd_pkg::OFF_DST, 32'h0000_4001);
    chk("still busy", 32'h1, {31'h0, busy});
    kick(1'b1);
    wait_done();
    chk("second byte", 32'h4001, i_mem.wa_q[1]);
    rd("fixed source", dcd_pkg::OFF_SRC, 32'h0000_3000);
    // relative linked descriptor that triggers itself
    wr(dcd_pkg::OFF_STAT, 32'h2);
    i_mem.wa_q.delete();
    i_mem.wd_q.delete();
    i_mem.mem[32'h500] = 32'hc830_0008;
    i_mem.mem[32'h504] = 32'h0000_0010;
    i_mem.mem[32'h508] = 32'h0000_0020;
    i_mem.mem[32'h50c] = 32'h0000_0600;
    wr(dcd_pkg::OFF_LINK, 32'h0000_0500);
    wr(dcd_pkg::OFF_CMD, 32'h2);
    wait_done();
    chk_wr(0, 32'h4022, 32'h3010_cfef);
    rd("linked source", dcd_pkg::OFF_SRC, 32'h0000_3014);
    rd("linked destination", dcd_pkg::OFF_DST, 32'h0000_4026);
    rd("next link", dcd_pkg::OFF_LINK, 32'h0000_0600);
    rd("loaded control", dcd_pkg::OFF_CTRL, 32'hc830_0000);
    chk("addressing kinds", 32'h3, {30'h0, r[31:30]});
    // linked immediate write: the source field goes out as one word, no request needed
    wr(dcd_pkg::OFF_STAT, 32'h2);
    i_mem.wa_q.delete();
    i_mem.wd_q.delete();
    i_mem.mem[32'h700] = 32'h0010_0002;
    i_mem.mem[32'h704] = 32'h1234_5678;
    i_mem.mem[32'h708] = 32'h0000_7000;
    i_mem.mem[32'h70c] = 32'h0000_0000;
    wr(dcd_pkg::OFF_LINK, 32'h0000_0700);
    wr(dcd_pkg::OFF_CMD, 32'h2);
    wait_done();
    chk_wr(0, 32'h7000, 32'h1234_5678);
    rd("immediate destination", dcd_pkg::OFF_DST, 32'h0000_7000);
    test_done();
  end
endmodule // tb

bind dcd_channel dcd_monitor i_mon (.clk_i, .resetn_i, .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i,
  .prdata_o, .pready_o, .pslverr_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_size_o, .mem_ack_i, .busy_o,
  .done_flag_o, .round_robin_share_o);
